// file: epm_cmd.sv
`timescale 1ns/100ps
`include "epm_defs.svh"
module epm_cmd #(
    parameter int DATA_BYTES = `EPM_DATA_BYTES,
    parameter int STAT_BYTES = `EPM_STAT_BYTES
) (
    input  wire logic                   CLK_SYS,
    input  wire logic                   RST,
    input  wire logic                   CE,
    input  wire logic                   BUS_RESET,
    input  wire logic                   SLOT_WR,
    input  wire logic                   WR_BIT,
    input  wire logic                   SLOT_RD,
    output logic                        RD_BIT,
    input  wire logic                   PROG_PULSE,
    input  wire logic                   ST_WE,
    input  wire logic [`EPM_ADDR_W-1:0] ST_ADDR,
    input  wire logic [7:0]             ST_DATA
);
    localparam epm_pkg::epm_core_t CORE_RST = '{
        st: epm_pkg::S_CMD, mode: epm_pkg::M_NONE, hdr: 1'b0, sr: 8'h00, cnt: 4'h0,
        tx: `EPM_IDLE_TX, addr: '0, scratch: 8'h00};

    epm_pkg::epm_core_t     cr_reg;
    epm_pkg::epm_core_t     cr_next;
    epm_pkg::epm_crc_ctl_t  crc_ctl;
    epm_pkg::epm_prog_t     prog;
    epm_pkg::epm_prog_t     stat_prog;
    logic [15:0]            crc_q;
    logic [15:0]            crc_nx;
    logic [7:0]             nb;
    logic [7:0]             rd_data;
    logic [`EPM_ADDR_W-1:0] fa;
    logic [`EPM_ADDR_W-1:0] rd_addr;
    logic                   rd_stat;
    logic                   rx_done;
    logic                   tx_done;
    logic                   pg_end;

    assign nb        = {WR_BIT, cr_reg.sr[7:1]};
    assign stat_prog = '{we: ST_WE, addr: ST_ADDR, data: ST_DATA};

    epm_crc i_epm_crc (
        .clk    (CLK_SYS),
        .rst    (RST),
        .ce     (CE),
        .ctl    (crc_ctl),
        .crc_q  (crc_q),
        .crc_nx (crc_nx)
    );

    epm_mem #(
        .DATA_BYTES (DATA_BYTES),
        .STAT_BYTES (STAT_BYTES)
    ) i_epm_mem (
        .clk       (CLK_SYS),
        .rst       (RST),
        .ce        (CE),
        .prog      (prog),
        .stat_prog (stat_prog),
        .rd_stat   (rd_stat),
        .rd_addr   (rd_addr),
        .rd_data   (rd_data)
    );

    // fetch address comes from registered state, except in S_ADH where its high bits come straight from nb
    always_comb begin
        if (cr_reg.st == epm_pkg::S_ADH) begin
            fa = {nb[2:0], cr_reg.addr[7:0]};
        end else if (cr_reg.st == epm_pkg::S_PROG ||
                     (cr_reg.st == epm_pkg::S_RCRC && cr_reg.hdr)) begin
            fa = cr_reg.addr;
        end else begin
            fa = cr_reg.addr + 11'h001;
        end
        rd_stat = (cr_reg.mode == epm_pkg::M_STAT) ||
                  (cr_reg.mode == epm_pkg::M_EXT &&
                   (cr_reg.st == epm_pkg::S_ADH || (cr_reg.st == epm_pkg::S_RCRC && !cr_reg.hdr)));
        if (cr_reg.mode == epm_pkg::M_EXT && rd_stat) begin
            rd_addr = `EPM_REDIR_BASE + {5'h00, fa[10:5]};
        end else begin
            rd_addr = fa;
        end
    end

    always_comb begin
        cr_next = cr_reg;
        crc_ctl = '{ld: 1'b0, ld_val: `EPM_CRC_CLEAR, sh_a: 1'b0, a: nb, sh_b: 1'b0, b: rd_data};
        prog    = '{we: 1'b0, addr: cr_reg.addr, data: cr_reg.scratch};
        rx_done = SLOT_WR && cr_reg.cnt == `EPM_BYTE_LAST_BIT;
        tx_done = SLOT_RD && cr_reg.cnt == ((cr_reg.st == epm_pkg::S_RCRC) ? `EPM_CRC_LAST_BIT
                                                                         : `EPM_BYTE_LAST_BIT);
        pg_end  = (cr_reg.mode == epm_pkg::M_STAT) ? (cr_reg.addr[2:0] == `EPM_STAT_PG_END)
                                                   : (cr_reg.addr[4:0] == `EPM_DATA_PG_END);
        case (cr_reg.st)
            epm_pkg::S_CMD, epm_pkg::S_ADL, epm_pkg::S_ADH, epm_pkg::S_WDATA: begin
                if (SLOT_WR) begin
                    cr_next.sr  = nb;
                    cr_next.cnt = cr_reg.cnt + 4'h1;
                end
            end
            epm_pkg::S_RDATA, epm_pkg::S_REDIR, epm_pkg::S_RCRC, epm_pkg::S_VERIFY, epm_pkg::S_ONES: begin
                if (SLOT_RD) begin
                    cr_next.tx  = {1'b1, cr_reg.tx[15:1]};
                    cr_next.cnt = cr_reg.cnt + 4'h1;
                end
            end
            default: begin
            end
        endcase
        if (rx_done || tx_done) begin
            cr_next.cnt = 4'h0;
        end
        case (cr_reg.st)
            epm_pkg::S_CMD: begin
                if (rx_done) begin
                    crc_ctl.ld   = 1'b1;
                    crc_ctl.sh_a = 1'b1;
                    cr_next.st   = epm_pkg::S_ADL;
                    case (nb)
                        `EPM_CMD_STAT: cr_next.mode = epm_pkg::M_STAT;
                        `EPM_CMD_EXT:  cr_next.mode = epm_pkg::M_EXT;
                        `EPM_CMD_WR:   cr_next.mode = epm_pkg::M_WR;
                        `EPM_CMD_SWR:  cr_next.mode = epm_pkg::M_SWR;
                        default: begin
                            cr_next.mode = epm_pkg::M_NONE;
                            cr_next.st   = epm_pkg::S_ONES;
                        end
                    endcase
                end
            end
            epm_pkg::S_ADL: begin
                if (rx_done) begin
                    crc_ctl.sh_a         = 1'b1;
                    cr_next.addr[7:0]    = nb;
                    cr_next.st           = epm_pkg::S_ADH;
                end
            end
            epm_pkg::S_ADH: begin
                if (rx_done) begin
                    crc_ctl.sh_a = 1'b1;
                    cr_next.addr = fa;
                    if (cr_reg.mode == epm_pkg::M_STAT || cr_reg.mode == epm_pkg::M_EXT) begin
                        crc_ctl.sh_b = 1'b1;
                        cr_next.tx   = {8'hFF, rd_data};
                        cr_next.hdr  = cr_reg.mode == epm_pkg::M_EXT;
                        cr_next.st   = (cr_reg.mode == epm_pkg::M_EXT) ? epm_pkg::S_REDIR
                                                                       : epm_pkg::S_RDATA;
                    end else begin
                        cr_next.st = epm_pkg::S_WDATA;
                    end
                end
            end
            epm_pkg::S_WDATA: begin
                if (rx_done) begin
                    crc_ctl.sh_a    = 1'b1;
                    cr_next.scratch = nb;
                    if (cr_reg.mode == epm_pkg::M_SWR) begin
                        cr_next.st = epm_pkg::S_PROG;
                    end else begin
                        cr_next.tx = crc_nx;
                        cr_next.st = epm_pkg::S_RCRC;
                    end
                end
            end
            epm_pkg::S_RDATA: begin
                if (tx_done) begin
                    if (pg_end) begin
                        cr_next.tx = crc_q;
                        cr_next.st = epm_pkg::S_RCRC;
                    end else begin
                        cr_next.addr = fa;
                        cr_next.tx   = {8'hFF, rd_data};
                        crc_ctl.sh_b = 1'b1;
                    end
                end
            end
            epm_pkg::S_REDIR: begin
                if (tx_done) begin
                    cr_next.tx = crc_q;
                    cr_next.st = epm_pkg::S_RCRC;
                end
            end
            epm_pkg::S_RCRC: begin
                if (tx_done) begin
                    cr_next.tx = {8'hFF, rd_data};
                    crc_ctl.ld = 1'b1;
                    if (cr_reg.mode == epm_pkg::M_WR) begin
                        crc_ctl.ld = 1'b0;
                        cr_next.tx = `EPM_IDLE_TX;
                        cr_next.st = epm_pkg::S_PROG;
                    end else if (cr_reg.hdr) begin
                        crc_ctl.sh_b = 1'b1;
                        cr_next.hdr  = 1'b0;
                        cr_next.st   = epm_pkg::S_RDATA;
                    end else if (cr_reg.addr >= ((cr_reg.mode == epm_pkg::M_STAT) ? `EPM_STAT_LAST
                                                                                 : `EPM_DATA_LAST)) begin
                        crc_ctl.ld = 1'b0;
                        cr_next.tx = `EPM_IDLE_TX;
                        cr_next.st = epm_pkg::S_ONES;
                    end else begin
                        crc_ctl.sh_b = 1'b1;
                        cr_next.addr = fa;
                        cr_next.hdr  = cr_reg.mode == epm_pkg::M_EXT;
                        cr_next.st   = (cr_reg.mode == epm_pkg::M_EXT) ? epm_pkg::S_REDIR
                                                                       : epm_pkg::S_RDATA;
                    end
                end
            end
            epm_pkg::S_PROG: begin
                // no crc check here: the master alone decides to pulse
                if (PROG_PULSE) begin
                    prog.we    = 1'b1;
                    cr_next.tx = {8'hFF, rd_data & cr_reg.scratch};
                    cr_next.st = epm_pkg::S_VERIFY;
                end
            end
            epm_pkg::S_VERIFY: begin
                if (tx_done) begin
                    cr_next.addr   = fa;
                    crc_ctl.ld     = 1'b1;
                    crc_ctl.ld_val = {5'h00, fa};
                    cr_next.tx     = `EPM_IDLE_TX;
                    cr_next.st     = epm_pkg::S_WDATA;
                end
            end
            epm_pkg::S_ONES: begin
            end
            default: begin
                cr_next = CORE_RST;
            end
        endcase
        if (BUS_RESET) begin
            cr_next      = CORE_RST;
            crc_ctl.ld   = 1'b1;
            crc_ctl.sh_a = 1'b0;
            crc_ctl.sh_b = 1'b0;
            prog.we      = 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            cr_reg <= CORE_RST;
        end else if (CE) begin
            cr_reg <= cr_next;
        end
    end

    assign RD_BIT = cr_reg.tx[0];

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    ones_after_end_a: assert property (cr_reg.st == epm_pkg::S_ONES && CE && SLOT_RD && !BUS_RESET |=> RD_BIT)
        else $error("read slot after end did not return one");
    reset_abort_a: assert property (CE && BUS_RESET |=> cr_reg.st == epm_pkg::S_CMD && RD_BIT)
        else $error("bus reset did not abort the command");
    stat_page_end_a: assert property (CE && !BUS_RESET && cr_reg.st == epm_pkg::S_RDATA && tx_done &&
        cr_reg.mode == epm_pkg::M_STAT && cr_reg.addr[2:0] == 3'h7 |=> cr_reg.st == epm_pkg::S_RCRC)
        else $error("status crc not inserted at page end");
    ext_page_end_a: assert property (CE && !BUS_RESET && cr_reg.st == epm_pkg::S_RDATA && tx_done &&
        cr_reg.mode == epm_pkg::M_EXT && cr_reg.addr[4:0] == 5'h1F |=> cr_reg.tx == $past(crc_q))
        else $error("page crc not loaded at page end");
    redir_crc_a: assert property (CE && !BUS_RESET && cr_reg.st == epm_pkg::S_REDIR && tx_done
        |=> cr_reg.st == epm_pkg::S_RCRC && cr_reg.hdr)
        else $error("redirection byte not followed by header crc");
    verify_data_a: assert property (CE && !BUS_RESET && cr_reg.st == epm_pkg::S_PROG && PROG_PULSE
        |=> cr_reg.st == epm_pkg::S_VERIFY && cr_reg.tx[7:0] == ($past(rd_data) & $past(cr_reg.scratch)))
        else $error("verify byte is not the programmed value");
    addr_incr_a: assert property (CE && !BUS_RESET && cr_reg.st == epm_pkg::S_VERIFY && tx_done
        |=> cr_reg.addr == $past(cr_reg.addr) + 11'h001 && crc_q == {5'h00, cr_reg.addr})
        else $error("address not incremented into crc after verify");
    speed_skip_a: assert property (CE && !BUS_RESET && cr_reg.st == epm_pkg::S_WDATA && rx_done &&
        cr_reg.mode == epm_pkg::M_SWR |=> cr_reg.st == epm_pkg::S_PROG)
        else $error("speed write did not skip the crc");
    lsb_first_a: assert property (CE && !BUS_RESET && SLOT_RD && !tx_done &&
        cr_reg.st inside {epm_pkg::S_RDATA, epm_pkg::S_RCRC} |=> RD_BIT == $past(cr_reg.tx[1]))
        else $error("read bits not sent lsb first");

    prog_pulse_c: cover property (cr_reg.st == epm_pkg::S_PROG && CE && PROG_PULSE);
    ext_header_c: cover property (cr_reg.st == epm_pkg::S_RCRC && cr_reg.hdr && CE && tx_done);
    stat_crc_c:   cover property (cr_reg.st == epm_pkg::S_RCRC && cr_reg.mode == epm_pkg::M_STAT && CE && tx_done);
    speed_wr_c:   cover property (cr_reg.st == epm_pkg::S_VERIFY && cr_reg.mode == epm_pkg::M_SWR && CE && tx_done);
endmodule : epm_cmd

// file: epm_cmd_tb_top.sv
`timescale 1ns/100ps
`include "epm_defs.svh"
`define CK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module epm_cmd_tb_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    logic        st_we = 1'b0;
    logic [10:0] st_addr = 11'h000;
    logic [7:0]  st_data = 8'h00;
    logic [15:0] v;
    logic [15:0] c;
    logic        rd_bit, bus_reset, slot_wr, wr_bit, slot_rd, prog_pulse;
    int          num_errors = 0;
    int          n_compared = 0;
    initial forever #5 clk = ~clk;
    epm_cmd i_epm_cmd (.CLK_SYS(clk), .RST(rst), .CE(ce), .BUS_RESET(bus_reset), .SLOT_WR(slot_wr),
        .WR_BIT(wr_bit), .SLOT_RD(slot_rd), .RD_BIT(rd_bit), .PROG_PULSE(prog_pulse),
        .ST_WE(st_we), .ST_ADDR(st_addr), .ST_DATA(st_data));
    epm_master i_epm_master (.clk(clk), .rd_bit(rd_bit), .bus_reset(bus_reset), .slot_wr(slot_wr),
        .wr_bit(wr_bit), .slot_rd(slot_rd), .prog_pulse(prog_pulse));
    function automatic logic [15:0] crc(input logic [15:0] s, input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            s = (s[0] ^ b[i]) ? ((s >> 1) ^ `EPM_CRC_POLY) : (s >> 1);
        end
        return s;
    endfunction : crc
    function automatic logic [15:0] crc4(input logic [7:0] a, b, d, e);
        return crc(crc(crc(crc(16'h0000, a), b), d), e);
    endfunction : crc4
    task automatic w(input logic [7:0] b);
        i_epm_master.wr_byte(b);
    endtask : w
    task automatic r(input int n);
        i_epm_master.rd_bits(n, v);
    endtask : r
    task automatic hdr(input logic [7:0] cmd, lo, hi);
        w(cmd);
        w(lo);
        w(hi);
    endtask : hdr
    task automatic st(input logic [10:0] a, input logic [7:0] d);
        @(posedge clk);
        st_we   <= 1'b1;
        st_addr <= a;
        st_data <= d;
        @(posedge clk);
        st_we   <= 1'b0;
    endtask : st
    task automatic t_write();
        hdr(`EPM_CMD_WR, 8'h05, 8'h00);
        w(8'hA5);
        c = crc4(8'h0F, 8'h05, 8'h00, 8'hA5);
        // frozen clock enable: read slots are ignored and the first crc bit stands
        ce <= 1'b0;
        r(8);
        ce <= 1'b1;
        `CK(v[7:0], {8{c[0]}})
        r(16);
        `CK(v, crc4(8'h0F, 8'h05, 8'h00, 8'hA5))
        i_epm_master.pulse();
        r(8);
        `CK(v[7:0], 8'hA5)
        w(8'h3C);
        r(16);
        `CK(v, crc(16'h0006, 8'h3C))
        i_epm_master.pulse();
        r(8);
        `CK(v[7:0], 8'h3C)
        i_epm_master.breset();
        $display("t_write done");
    endtask : t_write
    // upper address bits must be dropped, so this lands on the byte written above
    task automatic t_speed();
        hdr(`EPM_CMD_SWR, 8'h05, 8'hF8);
        w(8'h0F);
        i_epm_master.pulse();
        r(8);
        `CK(v[7:0], 8'h05)
        w(8'hF0);
        i_epm_master.pulse();
        r(8);
        `CK(v[7:0], 8'h30)
        i_epm_master.breset();
        $display("t_speed done");
    endtask : t_speed
    task automatic t_ext();
        logic [7:0] e;
        st(11'h100, 8'hFD);
        hdr(`EPM_CMD_EXT, 8'h04, 8'h00);
        r(8);
        `CK(v[7:0], 8'hFD)
        r(16);
        `CK(v, crc4(8'hA5, 8'h04, 8'h00, 8'hFD))
        c = 16'h0000;
        for (int a = 4; a < 32; a++) begin
            e = (a == 5) ? 8'h05 : (a == 6) ? 8'h30 : 8'hFF;
            r(8);
            `CK(v[7:0], e)
            c = crc(c, e);
        end
        r(16);
        `CK(v, c)
        r(8);
        `CK(v[7:0], 8'hFF)
        r(16);
        `CK(v, crc(16'h0000, 8'hFF))
        r(8);
        `CK(v[7:0], 8'hFF)
        i_epm_master.breset();
        $display("t_ext done");
    endtask : t_ext
    // follow the redirection left on page 0, then read out the last two bytes of the field
    task automatic t_redir();
        logic [10:0] a;
        hdr(`EPM_CMD_EXT, 8'h00, 8'h00);
        r(8);
        a = (v[7:0] == 8'hFF) ? 11'h000 : {~v[5:0], 5'h00};
        `CK(a, 11'h040)
        i_epm_master.breset();
        hdr(`EPM_CMD_EXT, a[7:0], {5'h00, a[10:8]});
        r(8);
        `CK(v[7:0], 8'hFF)
        i_epm_master.breset();
        hdr(`EPM_CMD_EXT, 8'hFE, 8'h07);
        r(8);
        `CK(v[7:0], 8'hFF)
        r(16);
        `CK(v, crc4(8'hA5, 8'hFE, 8'h07, 8'hFF))
        r(16);
        `CK(v, 16'hFFFF)
        r(16);
        `CK(v, crc(crc(16'h0000, 8'hFF), 8'hFF))
        r(16);
        `CK(v, 16'hFFFF)
        i_epm_master.breset();
        $display("t_redir done");
    endtask : t_redir
    task automatic t_stat();
        st(11'h13F, 8'h5A);
        hdr(`EPM_CMD_STAT, 8'h36, 8'h01);
        r(16);
        `CK(v, 16'hFFFF)
        r(16);
        `CK(v, crc(crc4(8'hAA, 8'h36, 8'h01, 8'hFF), 8'hFF))
        c = 16'h0000;
        for (int i = 0; i < 4; i++) begin
            r(16);
            `CK(v, (i == 3) ? 16'h5AFF : 16'hFFFF)
            c = crc(crc(c, 8'hFF), (i == 3) ? 8'h5A : 8'hFF);
        end
        r(16);
        `CK(v, c)
        r(16);
        `CK(v, 16'hFFFF)
        i_epm_master.breset();
        $display("t_stat done");
    endtask : t_stat
    task automatic print_verdict();
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_write();
        t_speed();
        t_ext();
        t_redir();
        t_stat();
        print_verdict();
    end
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        print_verdict();
    end
endmodule : epm_cmd_tb_top

// file: epm_crc.sv
`timescale 1ns/100ps
`include "epm_defs.svh"
module epm_crc (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  ce,
    input  wire epm_pkg::epm_crc_ctl_t ctl,
    output logic [15:0]                crc_q,
    output logic [15:0]                crc_nx
);
    epm_pkg::epm_crc_st_t s_reg;
    epm_pkg::epm_crc_st_t s_next;

    // reflected form: lsb-first shifting
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            if (r[0] ^ b[i]) begin
                r = (r >> 1) ^ `EPM_CRC_POLY;
            end else begin
                r = r >> 1;
            end
        end
        return r;
    endfunction : crc_byte

    always_comb begin
        s_next.crc = ctl.ld ? ctl.ld_val : s_reg.crc;
        if (ctl.sh_a) begin
            s_next.crc = crc_byte(s_next.crc, ctl.a);
        end
        if (ctl.sh_b) begin
            s_next.crc = crc_byte(s_next.crc, ctl.b);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_reg.crc <= `EPM_CRC_CLEAR;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    assign crc_q  = s_reg.crc;
    assign crc_nx = s_next.crc;
endmodule : epm_crc

// file: epm_defs.svh
`ifndef EPM_DEFS_SVH
`define EPM_DEFS_SVH

`define EPM_ADDR_W          11
`define EPM_CMD_STAT        8'hAA
`define EPM_CMD_EXT         8'hA5
`define EPM_CMD_WR          8'h0F
`define EPM_CMD_SWR         8'hF3
`define EPM_STAT_LAST       11'h13F
`define EPM_DATA_LAST       11'h7FF
`define EPM_REDIR_BASE      11'h100
`define EPM_STAT_PG_END     3'h7
`define EPM_DATA_PG_END     5'h1F
`define EPM_STAT_BLK0_LO    11'h000
`define EPM_STAT_BLK0_HI    11'h007
`define EPM_STAT_BLK1_LO    11'h020
`define EPM_STAT_BLK1_HI    11'h027
`define EPM_STAT_BLK2_LO    11'h040
`define EPM_STAT_BLK2_HI    11'h047
`define EPM_STAT_BLK3_LO    11'h100
`define EPM_STAT_BLK3_HI    11'h13F
`define EPM_ERASED          8'hFF
`define EPM_CRC_POLY        16'hA001
`define EPM_CRC_CLEAR       16'h0000
`define EPM_IDLE_TX         16'hFFFF
`define EPM_BYTE_LAST_BIT   4'h7
`define EPM_CRC_LAST_BIT    4'hF
`define EPM_DATA_BYTES      2048
`define EPM_STAT_BYTES      320

`endif

// file: epm_master.sv
`timescale 1ns/100ps
module epm_master (
    input  wire logic clk,
    input  wire logic rd_bit,
    output logic      bus_reset,
    output logic      slot_wr,
    output logic      wr_bit,
    output logic      slot_rd,
    output logic      prog_pulse
);
    initial {bus_reset, slot_wr, wr_bit, slot_rd, prog_pulse} = 5'h04;
    // between slots the data line shows the inverse bit, so a stale sample cannot pass
    task automatic wr_byte(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            slot_wr <= 1'b1;
            wr_bit  <= b[i];
            @(posedge clk);
            slot_wr <= 1'b0;
            wr_bit  <= ~b[i];
        end
    endtask : wr_byte
    task automatic rd_bits(input int n, output logic [15:0] v);
        v = 16'hFFFF;
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            slot_rd <= 1'b1;
            @(negedge clk);
            v[i] = rd_bit;
            @(posedge clk);
            slot_rd <= 1'b0;
        end
    endtask : rd_bits
    // end of the 12 V pulse only; its length is timed here, not by the device
    task automatic pulse();
        @(posedge clk);
        prog_pulse <= 1'b1;
        @(posedge clk);
        prog_pulse <= 1'b0;
    endtask : pulse
    task automatic breset();
        @(posedge clk);
        bus_reset <= 1'b1;
        @(posedge clk);
        bus_reset <= 1'b0;
    endtask : breset
endmodule : epm_master

// file: epm_mem.sv
`timescale 1ns/100ps
`include "epm_defs.svh"
module epm_mem #(
    parameter int DATA_BYTES = `EPM_DATA_BYTES,
    parameter int STAT_BYTES = `EPM_STAT_BYTES
) (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic                   ce,
    input  wire epm_pkg::epm_prog_t     prog,
    input  wire epm_pkg::epm_prog_t     stat_prog,
    input  wire logic                   rd_stat,
    input  wire logic [`EPM_ADDR_W-1:0] rd_addr,
    output logic [7:0]                  rd_data
);
    typedef struct packed {
        logic [DATA_BYTES-1:0][7:0] data;
        logic [STAT_BYTES-1:0][7:0] stat;
    } epm_mem_st_t;

    epm_mem_st_t m_reg;
    epm_mem_st_t m_next;

    // holes in the status field read as erased and ignore programming
    function automatic logic stat_impl(input logic [`EPM_ADDR_W-1:0] a);
        return (a >= `EPM_STAT_BLK0_LO && a <= `EPM_STAT_BLK0_HI) ||
               (a >= `EPM_STAT_BLK1_LO && a <= `EPM_STAT_BLK1_HI) ||
               (a >= `EPM_STAT_BLK2_LO && a <= `EPM_STAT_BLK2_HI) ||
               (a >= `EPM_STAT_BLK3_LO && a <= `EPM_STAT_BLK3_HI);
    endfunction : stat_impl

    always_comb begin
        m_next = m_reg;
        for (int i = 0; i < DATA_BYTES; i++) begin
            if (prog.we && int'(prog.addr) == i) begin
                m_next.data[i] = m_reg.data[i] & prog.data;
            end
        end
        for (int j = 0; j < STAT_BYTES; j++) begin
            if (stat_prog.we && int'(stat_prog.addr) == j && stat_impl(stat_prog.addr)) begin
                m_next.stat[j] = m_reg.stat[j] & stat_prog.data;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            m_reg <= '1;
        end else if (ce) begin
            m_reg <= m_next;
        end
    end

    always_comb begin
        rd_data = `EPM_ERASED;
        if (rd_stat) begin
            if (stat_impl(rd_addr) && int'(rd_addr) < STAT_BYTES) begin
                rd_data = m_reg.stat[rd_addr];
            end
        end else if (int'(rd_addr) < DATA_BYTES) begin
            rd_data = m_reg.data[rd_addr];
        end
    end
endmodule : epm_mem

// file: epm_pkg.sv
`include "epm_defs.svh"
package epm_pkg;
    typedef enum logic [3:0] {
        S_CMD    = 4'h0,
        S_ADL    = 4'h1,
        S_ADH    = 4'h2,
        S_WDATA  = 4'h3,
        S_RDATA  = 4'h4,
        S_REDIR  = 4'h5,
        S_RCRC   = 4'h6,
        S_PROG   = 4'h7,
        S_VERIFY = 4'h8,
        S_ONES   = 4'h9
    } epm_state_t;

    typedef enum logic [2:0] {
        M_NONE = 3'h0,
        M_STAT = 3'h1,
        M_EXT  = 3'h2,
        M_WR   = 3'h3,
        M_SWR  = 3'h4
    } epm_mode_t;

    typedef struct packed {
        epm_state_t              st;
        epm_mode_t               mode;
        logic                    hdr;
        logic [7:0]              sr;
        logic [3:0]              cnt;
        logic [15:0]             tx;
        logic [`EPM_ADDR_W-1:0]  addr;
        logic [7:0]              scratch;
    } epm_core_t;

    typedef struct packed {
        logic        ld;
        logic [15:0] ld_val;
        logic        sh_a;
        logic [7:0]  a;
        logic        sh_b;
        logic [7:0]  b;
    } epm_crc_ctl_t;

    typedef struct packed {
        logic [15:0] crc;
    } epm_crc_st_t;

    typedef struct packed {
        logic                    we;
        logic [`EPM_ADDR_W-1:0]  addr;
        logic [7:0]              data;
    } epm_prog_t;
endpackage : epm_pkg
